// [rtl/double_tap_window_timer.sv]
/*
 * Double tap window timer: sequences first pulse, latency, window and
 * second pulse of the tap detector.
 * Assumes the threshold comparison arrives on the system clock and that
 * software holds the timing fields steady while a sequence runs.
 */
`timescale 1ns/1ns
`default_nettype none
module double_tap_window_timer
    import tap_window_pkg::*;
(
    input wire logic clk,  // System clock, 20 MHz.
    input wire logic rst_n,  // Synchronous reset, active low.
    input wire rate_cfg_t cfg,  // Rate, mode and filter selection.
    input wire tap_times_t times,  // Window, latency and limit counts.
    input wire tap_input_t tap_in,  // Threshold flag and double enable.
    output logic single_tap,  // Pulse: valid single pulse seen.
    output logic double_tap,  // Pulse: valid double pulse seen.
    output logic first_seen,  // Level: first pulse accepted.
    output logic latency_done,  // Level: waiting in window.
    output logic [7:0] window_left  // Remaining window steps.
);

    typedef enum {
        IDLE, FIRST_PULSE, LATENCY, WINDOW, SECOND_PULSE, WAIT_LOW
    } tap_state_t;

    tap_state_t state, next_state;
    logic [7:0] count, next_count;
    logic above_d, next_above_d;
    logic next_single_tap, next_double_tap, next_first_seen;
    logic next_latency_done;
    logic [7:0] next_window_left;
    logic step_tick, restart, rise, fall;

    ////////////////////////////////////////////////////////////////////////
    tap_step_gen step_gen (
        .clk(clk),
        .rst_n(rst_n),
        .restart(restart),
        .cfg(cfg),
        .step_tick(step_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        rise = tap_in.over_threshold && !above_d;
        fall = !tap_in.over_threshold && above_d;
        next_above_d = tap_in.over_threshold;
        next_state = state;
        next_count = count;
        next_single_tap = 1'b0;
        next_double_tap = 1'b0;
        restart = 1'b0;
        unique case (state)
            IDLE: begin
                if (rise) begin
                    next_state = FIRST_PULSE;
                    next_count = 8'h00;
                    restart = 1'b1;
                end
            end
            FIRST_PULSE: begin
                if (fall) begin
                    next_single_tap = 1'b1;
                    next_count = 8'h00;
                    restart = 1'b1;
                    next_state = tap_in.double_enable ? LATENCY : IDLE;
                end else if (step_tick) begin
                    if (count >= times.time_limit) begin
                        next_state = WAIT_LOW;
                    end else begin
                        next_count = count + 8'h01;
                    end
                end
            end
            LATENCY: begin
                // Pulse starts are ignored while this runs.
                if (step_tick || times.latency == 8'h00) begin
                    if (count + 8'h01 >= times.latency) begin
                        next_state = WINDOW;
                        next_count = 8'h00;
                        restart = 1'b1;
                    end else begin
                        next_count = count + 8'h01;
                    end
                end
            end
            WINDOW: begin
                if (rise && count < times.window) begin
                    next_state = SECOND_PULSE;
                    next_count = 8'h00;
                    restart = 1'b1;
                end else if (count >= times.window) begin
                    next_state = IDLE;
                end else if (step_tick) begin
                    next_count = count + 8'h01;
                end
            end
            SECOND_PULSE: begin
                if (fall) begin
                    next_double_tap = 1'b1;
                    next_state = IDLE;
                end else if (step_tick) begin
                    if (count >= times.time_limit) begin
                        next_state = WAIT_LOW;
                    end else begin
                        next_count = count + 8'h01;
                    end
                end
            end
            WAIT_LOW: begin
                if (!tap_in.over_threshold) begin
                    next_state = IDLE;
                end
            end
        endcase
        next_first_seen = (next_state == LATENCY) || (next_state == WINDOW);
        next_latency_done = (next_state == WINDOW);
        next_window_left = (next_state == WINDOW)
                           ? times.window - next_count : 8'h00;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= IDLE;
            count <= 8'h00;
            above_d <= 1'b0;
            single_tap <= 1'b0;
            double_tap <= 1'b0;
            first_seen <= 1'b0;
            latency_done <= 1'b0;
            window_left <= 8'h00;
        end else begin
            state <= next_state;
            count <= next_count;
            above_d <= next_above_d;
            single_tap <= next_single_tap;
            double_tap <= next_double_tap;
            first_seen <= next_first_seen;
            latency_done <= next_latency_done;
            window_left <= next_window_left;
        end
    end

endmodule
`default_nettype wire

// [rtl/tap_window_pkg.sv]
/*
 * Package for the double tap window timer: mode codes, time step tables,
 * reset values and the carrier structs.
 * Assumes a 20 MHz system clock; time steps are counted in its cycles alone.
 */
package tap_window_pkg;

    // Clock figures.
    localparam int CLK_HZ = 20_000_000;

    // Reset values of the timing fields.
    localparam logic [7:0] WINDOW_RESET = 8'h00;
    localparam logic [7:0] LATENCY_RESET = 8'h00;
    localparam logic [7:0] TMLT_RESET = 8'h00;

    // Output data rate select codes, fastest first.
    localparam logic [2:0] ODR_800 = 3'h0;
    localparam logic [2:0] ODR_400 = 3'h1;
    localparam logic [2:0] ODR_200 = 3'h2;
    localparam logic [2:0] ODR_100 = 3'h3;
    localparam logic [2:0] ODR_50 = 3'h4;
    localparam logic [2:0] ODR_12P5 = 3'h5;
    localparam logic [2:0] ODR_6P25 = 3'h6;
    localparam logic [2:0] ODR_1P56 = 3'h7;

    // Oversampling mode codes.
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_LOW_POWER_LOW_NOISE = 2'h1;
    localparam logic [1:0] MODE_HIGH_RES = 2'h2;
    localparam logic [1:0] MODE_LOW_POWER = 2'h3;

    // Smallest time step, 0.625 ms, in microseconds times eight.
    localparam int BASE_STEP_US_X8 = 5_000;
    // Base step expressed in system clock cycles (12500 cycles).
    localparam int BASE_STEP_CYCLES = CLK_HZ / 1_000 * BASE_STEP_US_X8
                                      / 8_000;

    // Window step in units of 0.625 ms, filter off, per data rate.
    // Normal / low-power-low-noise / low power columns; high resolution
    // is fixed at 1.25 ms. Filter on doubles every entry.
    localparam logic [9:0] WIN_STEP_NORMAL [8] =
        '{10'h002, 10'h002, 10'h004, 10'h008, 10'h010, 10'h010,
          10'h010, 10'h010};
    localparam logic [9:0] WIN_STEP_LOW_POWER_LOW_NOISE_MODE [8] =
        '{10'h002, 10'h002, 10'h004, 10'h008, 10'h010, 10'h040,
          10'h040, 10'h040};
    localparam logic [9:0] WIN_STEP_LOWPWR [8] =
        '{10'h002, 10'h004, 10'h008, 10'h010, 10'h020, 10'h080,
          10'h080, 10'h080};
    localparam logic [9:0] WIN_STEP_HIRES = 10'h002;

    // Timing configuration carried to the detector.
    typedef struct packed {
        logic [2:0] odr;
        logic [1:0] mode;
        logic hpf_en;
    } rate_cfg_t;

    typedef struct packed {
        logic [7:0] window;
        logic [7:0] latency;
        logic [7:0] time_limit;
    } tap_times_t;

    typedef struct packed {
        logic over_threshold;
        logic double_enable;
    } tap_input_t;

endpackage

// [rtl/tap_step_gen.sv]
/*
 * Time step generator: emits a one-cycle tick every window time step.
 * Assumes its configuration is stable while a count is running.
 */
`timescale 1ns/1ns
`default_nettype none
module tap_step_gen
    import tap_window_pkg::*;
(
    input wire logic clk,  // System clock.
    input wire logic rst_n,  // Synchronous reset, active low.
    input wire logic restart,  // Restarts the step phase.
    input wire rate_cfg_t cfg,  // Rate, mode and filter selection.
    output logic step_tick  // One-cycle pulse per time step.
);

    logic [9:0] units;
    logic [13:0] base_cnt;
    logic [13:0] next_base_cnt;
    logic [9:0] unit_cnt;
    logic [9:0] next_unit_cnt;
    logic next_step_tick;
    logic base_tick;

    // Time step per rate and mode; filter on doubles it.
    always_comb begin
        unique case (cfg.mode)
            MODE_NORMAL: units = WIN_STEP_NORMAL[cfg.odr];
            MODE_LOW_POWER_LOW_NOISE: units = WIN_STEP_LOW_POWER_LOW_NOISE_MODE[cfg.odr];
            MODE_HIGH_RES: units = WIN_STEP_HIRES;
            MODE_LOW_POWER: units = WIN_STEP_LOWPWR[cfg.odr];
        endcase
        if (cfg.hpf_en) begin
            units = units << 1;
        end
    end

    always_comb begin
        base_tick = (base_cnt == 14'(BASE_STEP_CYCLES - 1));
        next_base_cnt = base_tick ? 14'h0000 : base_cnt + 14'h0001;
        next_unit_cnt = unit_cnt;
        next_step_tick = 1'b0;
        if (base_tick) begin
            if (unit_cnt + 10'h001 >= units) begin
                next_unit_cnt = 10'h000;
                next_step_tick = 1'b1;
            end else begin
                next_unit_cnt = unit_cnt + 10'h001;
            end
        end
        if (restart) begin
            next_base_cnt = 14'h0000;
            next_unit_cnt = 10'h000;
            next_step_tick = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            base_cnt <= 14'h0000;
            unit_cnt <= 10'h000;
            step_tick <= 1'b0;
        end else begin
            base_cnt <= next_base_cnt;
            unit_cnt <= next_unit_cnt;
            step_tick <= next_step_tick;
        end
    end

endmodule
`default_nettype wire

// [test/tap_window_asserts.sv]
/* Checker for the double tap window timer outputs.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module tap_window_asserts
    import tap_window_pkg::*;
(
    input wire logic clk,  // System clock.
    input wire logic rst_n,  // Synchronous reset, active low.
    input wire rate_cfg_t cfg,  // Rate selection.
    input wire tap_times_t times,  // Timing counts.
    input wire tap_input_t tap_in,  // Threshold and enable.
    input wire logic single_tap,  // Single pulse strobe.
    input wire logic double_tap,  // Double pulse strobe.
    input wire logic first_seen,  // First pulse level.
    input wire logic latency_done,  // Window level.
    input wire logic [7:0] window_left  // Remaining steps.
);
////////////////////////////////////////////////////////////////////////
default clocking cb @(posedge clk); endclocking
default disable iff (!rst_n);
sequence s_enter;
    !latency_done ##1 latency_done;
endsequence
property p_enter;
    s_enter |-> window_left == times.window;
endproperty
a_enter: assert property (p_enter) else $error("bad window load");
property p_bound;
    latency_done |-> window_left <= times.window;
endproperty
a_bound: assert property (p_bound) else $error("window overrun");
property p_idle_zero;
    !latency_done |-> window_left == 8'h00;
endproperty
a_idle_zero: assert property (p_idle_zero) else $error("window left");
property p_step;
    latency_done && $past(latency_done) |-> window_left == $past(window_left)
        || window_left == $past(window_left) - 8'h01;
endproperty
a_step: assert property (p_step) else $error("window jump");
property p_in_seq;
    latency_done |-> first_seen;
endproperty
a_in_seq: assert property (p_in_seq) else $error("window w/o first");
property p_single;
    single_tap |=> !single_tap;
endproperty
a_single: assert property (p_single) else $error("single too long");
property p_double;
    double_tap |-> $past(tap_in.double_enable) ##1 !double_tap;
endproperty
a_double: assert property (p_double) else $error("double strobe");
property p_on_fall;
    single_tap || double_tap |-> !$past(tap_in.over_threshold);
endproperty
a_on_fall: assert property (p_on_fall) else $error("tap before fall");
endmodule
`default_nettype wire

// [test/tb_top.sv]
/* Testbench for the double tap window timer: a double tap and an expiry.
   Assumes the 20 MHz clock and 800 Hz normal mode, with the filter off until the filter test. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
import tap_window_pkg::*;
logic clk = 1'b0;
logic rst_n = 1'b0;
rate_cfg_t cfg = '{ODR_800, MODE_NORMAL, 1'b0};
tap_times_t times = '{8'h02, 8'h00, 8'h01};
tap_input_t tap_in = '{1'b0, 1'b1};
logic single_tap, double_tap, first_seen, latency_done;
logic [7:0] window_left;
int miscompares = 0;
int samples_checked = 0;
int n;
`define CHECK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    miscompares++; $display("wrong value at %0t: %0h", $time, (g)); end end
double_tap_window_timer dut_u (.clk(clk), .rst_n(rst_n), .cfg(cfg),
    .times(times), .tap_in(tap_in), .single_tap(single_tap),
    .double_tap(double_tap), .first_seen(first_seen),
    .latency_done(latency_done), .window_left(window_left));
initial begin
    forever #25 clk = ~clk;
end
////////////////////////////////////////////////////////////////////////
task automatic tick();
    @(posedge clk);
    #5;
endtask
task automatic pulse(input int len);
    tap_in.over_threshold = 1'b1;
    repeat (len) tick();
    tap_in.over_threshold = 1'b0;
endtask
task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
endtask
// First pulse, then a second pulse right at the window start.
task automatic test_double();
    pulse(4);
    n = 0;
    while (single_tap !== 1'b1 && n < 100) begin tick(); n++; end
    `CHECK(single_tap, 1'b1)
    n = 0;
    while (latency_done !== 1'b1 && n < 30000) begin tick(); n++; end
    `CHECK(window_left, 8'h02)
    pulse(4);
    n = 0;
    while (double_tap !== 1'b1 && n < 100) begin tick(); n++; end
    `CHECK(double_tap, 1'b1)
    tick();
    `CHECK(double_tap, 1'b0)
endtask
// One step of 1.25 ms is 25000 cycles; no second pulse arrives.
task automatic test_expire();
    times.window = 8'h01;
    repeat (5) tick();
    pulse(4);
    n = 0;
    while (latency_done !== 1'b1 && n < 30000) begin tick(); n++; end
    `CHECK(latency_done, 1'b1)
    n = 0;
    while (latency_done === 1'b1 && n < 30000) begin tick(); n++; end
    `CHECK(n >= 24998 && n <= 25002, 1'b1)
    `CHECK(first_seen, 1'b0)
    `CHECK(double_tap, 1'b0)
endtask
// Filter on: a single-only tap, then an expiry at a 2.5 ms step.
task automatic test_filter();
    cfg.hpf_en = 1'b1;
    tap_in.double_enable = 1'b0;
    pulse(4);
    n = 0;
    while (single_tap !== 1'b1 && n < 100) begin tick(); n++; end
    `CHECK(single_tap, 1'b1)
    tick();
    `CHECK(first_seen, 1'b0)
    tap_in.double_enable = 1'b1;
    repeat (5) tick();
    pulse(4);
    n = 0;
    while (latency_done !== 1'b1 && n < 100) begin tick(); n++; end
    `CHECK(latency_done, 1'b1)
    n = 0;
    while (latency_done === 1'b1 && n < 60000) begin tick(); n++; end
    `CHECK(n >= 49998 && n <= 50002, 1'b1)
endtask
initial begin
    repeat (10) tick();
    rst_n = 1'b1;
    tick();
    test_double();
    test_expire();
    test_filter();
    summarize();
end
initial begin
    repeat (95000) @(posedge clk);
    miscompares++;
    summarize();
end
endmodule
bind double_tap_window_timer tap_window_asserts chk_u (.clk(clk),
    .rst_n(rst_n), .cfg(cfg), .times(times), .tap_in(tap_in),
    .single_tap(single_tap), .double_tap(double_tap),
    .first_seen(first_seen), .latency_done(latency_done),
    .window_left(window_left));
`default_nettype wire
